// ===== logic/cra_pkg.sv
// Constants shared by the config register attribute bank
// Assumes a 100 MHz clock and a 32-bit Avalon-MM word bus
package cra_pkg;
    // ********************************
    // Bus and timing
    // ********************************
    localparam int         DW          = 32;
    localparam int         AW          = 10;
    localparam int         BW          = 4;
    localparam int         CLK_MHZ     = 100;
    localparam int         CPU_RST_US  = 1000;
    localparam int         CPU_RST_CYC = CPU_RST_US * CLK_MHZ;
    localparam logic [3:0] BE_ALL      = 4'hF;
    localparam logic [3:0] BE_LO16     = 4'h3;
    localparam logic [3:0] BE_HI16     = 4'hC;
    // ********************************
    // Word indices, byte address is four times
    // ********************************
    localparam logic [9:0] IX_INDEX    = 10'h000;
    localparam logic [9:0] IX_ID       = 10'h001;
    localparam logic [9:0] IX_CTRL     = 10'h002;
    localparam logic [9:0] IX_STAT     = 10'h003;
    localparam logic [9:0] IX_STKY     = 10'h004;
    localparam logic [9:0] IX_CMD      = 10'h005;
    localparam logic [9:0] IX_EXT      = 10'h040;
    localparam logic [9:0] IX_LOW_END  = 10'h040;
    // ********************************
    // Field layout and reset values
    // ********************************
    localparam int         STRAP_W     = 4;
    localparam int         ID_CODE_LSB = 16;
    localparam int         LOCK_BIT    = 0;
    localparam int         LKF_LSB     = 4;
    localparam int         LKF_W       = 4;
    localparam int         WO_LSB      = 8;
    localparam int         WO_W        = 8;
    localparam int         SC_LSB      = 16;
    localparam int         SC_W        = 2;
    localparam int         EV_W        = 8;
    localparam int         SEV_LSB     = 8;
    localparam int         RS_BIT      = 16;
    localparam int         RWC_LSB     = 17;
    localparam int         RWC_W       = 3;
    localparam logic [2:0] RWC_RST     = 3'h7;
endpackage : cra_pkg

// ===== logic/cra_rst_if.sv
// Reset and strap carrier between the bank's modules
// Assumes one driver, the reset controller
`timescale 1ns/1ns
interface cra_rst_if;
    import cra_pkg::*;
    logic               cold;
    logic               warm;
    logic [STRAP_W-1:0] strap;
    modport src (output cold, warm, strap);
    modport dst (input cold, warm, strap);
endinterface : cra_rst_if

// ===== logic/cra_rst_ctl.sv
// Reset pin synchroniser, strap capture and processor reset timer
// Assumes pins asynchronous to clk, srst synchronous
`timescale 1ns/1ns
module cra_rst_ctl #(
    parameter int CPU_CYC = cra_pkg::CPU_RST_CYC
) (
    input  wire logic                        clk,
    input  wire logic                        srst,
    input  wire logic                        rst_in_n,
    input  wire logic [cra_pkg::STRAP_W-1:0] strap_pin,
    output logic                             cpu_rst_n,
    cra_rst_if.src                           rif
);
    import cra_pkg::*;
    localparam int CNT_W = $clog2(CPU_CYC + 1);
    logic [1:0]         rin_q;
    logic [STRAP_W-1:0] sp1_q;
    logic [STRAP_W-1:0] sp2_q;
    logic [STRAP_W-1:0] strap_q;
    logic [CNT_W-1:0]   cnt_q;
    logic               cpu_q;
    wire                in_rst = srst | ~rin_q[1];

    // ********************************
    // Synchronisers and strap capture
    // ********************************
    always_ff @(posedge clk) begin
        rin_q <= srst ? 2'h0 : {rin_q[0], rst_in_n};
        sp1_q <= strap_pin;
        sp2_q <= sp1_q;
        if (in_rst) begin
            strap_q <= sp2_q;
        end
    end

    // ********************************
    // Processor reset timer
    // ********************************
    always_ff @(posedge clk) begin
        if (in_rst) begin
            cnt_q <= '0;
            cpu_q <= 1'h0;
        end else if (cnt_q == CNT_W'(CPU_CYC - 1)) begin
            cpu_q <= 1'h1;
        end else begin
            cnt_q <= cnt_q + CNT_W'(1);
        end
    end

    assign cpu_rst_n = cpu_q;
    assign rif.cold  = srst;
    assign rif.warm  = ~rin_q[1];
    assign rif.strap = strap_q;

    cpu_rst_low_a: assert property (
        @(posedge clk) in_rst |=> !cpu_q)
        else $error("processor reset released during reset");
endmodule : cra_rst_ctl

// ===== logic/cra_w1c_bits.sv
// Group of write-one-to-clear status bits, optionally sticky
// Assumes set and clr on the same clock, cold and warm from the carrier
`timescale 1ns/1ns
module cra_w1c_bits #(
    parameter int W      = 8,
    parameter bit STICKY = 1'h0
) (
    input  wire logic         clk,
    cra_rst_if.dst            rif,
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    output logic      [W-1:0] q
);
    logic [W-1:0] q_q;
    wire          rst = rif.cold | (rif.warm & ~STICKY);

    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk) begin
            if (rst) begin
                q_q[i] <= 1'h0;
            end else if (set[i]) begin
                q_q[i] <= 1'h1;
            end else if (clr[i]) begin
                q_q[i] <= 1'h0;
            end
        end
    end
    assign q = q_q;

    set_wins_a: assert property (
        @(posedge clk) disable iff (rst)
        1'h1 |=> ((q_q & $past(set)) == $past(set)))
        else $error("status event lost");
    sticky_keep_a: assert property (
        @(posedge clk) disable iff (rif.cold)
        (STICKY && rif.warm && clr == '0) |=>
        ((q_q & $past(q_q)) == $past(q_q)))
        else $error("sticky status lost on warm reset");
endmodule : cra_w1c_bits

// ===== logic/cra_bank.sv
// Top of the config register attribute bank, Avalon-MM slave
// Assumes a master on CLOCK; reset pin and straps come from the board
//
// Notes on behaviour
// - Read-only bits return their value and ignore every write.
// - Read-set bit becomes 1 when read; writing 1 clears, 0 keeps.
// - Write-one-to-clear status set by hardware; written 0 does nothing.
// - Sticky write-one-to-clear bits survive warm reset, not cold reset.
// - Lockable fields accept writes until the lock bit is set.
// - Sticky read/write bits survive warm reset, default on cold reset.
// - Self-clearing bits cleared by hardware; lockable variant obeys the lock.
// - Plain write-clear bits readable; writing 1 clears, 0 keeps.
// - Write-once bits take the first write then become read-only.
// - Write-only bits read as zero, writes only cause side effects.
// - Reserved locations complete normally and read as zero.
// - Writes to reserved locations complete and change nothing.
// - Low 256 bytes take byte, word, dword; index register dword only.
// - Offsets 256 to 4095 take dword accesses only.
// - Multi-byte fields are little-endian, low byte at lowest address.
// - Full reset loads defaults, some taken from straps.
// - Straps captured while reset is asserted, used as defaults.
// - Processor reset low in reset, released about 1 ms after.
// - Index and configuration registers reachable by the processor.
// - Reset pin returns the controller logic to its reset state.
//
// Register access over Avalon-MM and the register offsets were left to the implementer.
`timescale 1ns/1ns
module cra_bank #(
    parameter int          CPU_RST_CYCLES = cra_pkg::CPU_RST_CYC,
    parameter logic [15:0] PART_CODE      = 16'h5A3C  // Arbitrary value
) (
    input  wire logic                        CLOCK,
    input  wire logic                        SRST,
    input  wire logic [cra_pkg::AW-1:0]      AVS_ADDRESS,
    input  wire logic                        AVS_READ,
    input  wire logic                        AVS_WRITE,
    input  wire logic [cra_pkg::DW-1:0]      AVS_WRITEDATA,
    input  wire logic [cra_pkg::BW-1:0]      AVS_BYTEENABLE,
    output logic      [cra_pkg::DW-1:0]      AVS_READDATA,
    output logic                             AVS_WAITREQUEST,
    input  wire logic                        SYSTEM_RESET_IN_N,
    input  wire logic [cra_pkg::STRAP_W-1:0] STRAP_IN,
    input  wire logic [2*cra_pkg::EV_W-1:0]  HW_EVENT,
    input  wire logic [cra_pkg::SC_W-1:0]    SC_DONE,
    output logic                             PROCESSOR_RESET_OUT_N,
    output logic [cra_pkg::LKF_W-1:0]        LOCKED_FIELD,
    output logic [cra_pkg::WO_W-1:0]         WRITE_ONCE_FIELD,
    output logic [cra_pkg::SC_W-1:0]         SC_CMD,
    output logic [cra_pkg::DW-1:0]           STICKY_CFG,
    output logic [cra_pkg::DW-1:0]           EXT_CFG,
    output logic                             CMD_PULSE,
    output logic [cra_pkg::DW-1:0]           CMD_DATA
);
    import cra_pkg::*;

    // ********************************
    // Reset control
    // ********************************
    cra_rst_if rif ();

    cra_rst_ctl #(
        .CPU_CYC   (CPU_RST_CYCLES)
    ) u_rst (
        .clk       (CLOCK),
        .srst      (SRST),
        .rst_in_n  (SYSTEM_RESET_IN_N),
        .strap_pin (STRAP_IN),
        .cpu_rst_n (PROCESSOR_RESET_OUT_N),
        .rif       (rif)
    );

    wire rst_all = rif.cold | rif.warm;

    // ********************************
    // State
    // ********************************
    logic              ack_q;
    logic              wait_q;
    logic [DW-1:0]     rdata_q;
    logic [DW-1:0]     index_q;
    logic              lock_q;
    logic [LKF_W-1:0]  lkf_q;
    logic [WO_W-1:0]   wo_q;
    logic              wo_done_q;
    logic [SC_W-1:0]   sc_q;
    logic              rs_q;
    logic [RWC_W-1:0]  rwc_q;
    logic [DW-1:0]     stky_q;
    logic [DW-1:0]     ext_q;
    logic              pulse_q;
    logic [DW-1:0]     cmd_q;
    logic [EV_W-1:0]   ev_q;
    logic [EV_W-1:0]   sev_q;

    // ********************************
    // Access decode
    // ********************************
    wire [BW-1:0] be      = AVS_BYTEENABLE;
    wire          req     = (AVS_READ | AVS_WRITE) & ~ack_q;
    wire          low_rgn = AVS_ADDRESS < IX_LOW_END;
    wire          be_sub  = $onehot(be) | be == BE_LO16 | be == BE_HI16;
    wire          dw_only = AVS_ADDRESS == IX_INDEX | ~low_rgn;
    wire          legal   = dw_only ? be == BE_ALL
                                    : (be == BE_ALL | be_sub);
    wire          hit_idx = legal & AVS_ADDRESS == IX_INDEX;
    wire          hit_id  = legal & AVS_ADDRESS == IX_ID;
    wire          hit_ctl = legal & AVS_ADDRESS == IX_CTRL;
    wire          hit_st  = legal & AVS_ADDRESS == IX_STAT;
    wire          hit_sk  = legal & AVS_ADDRESS == IX_STKY;
    wire          hit_cmd = legal & AVS_ADDRESS == IX_CMD;
    wire          hit_ext = legal & AVS_ADDRESS == IX_EXT;
    wire          rsvd    = ~(hit_idx | hit_id | hit_ctl | hit_st
                              | hit_sk | hit_cmd | hit_ext);
    wire          wr      = ack_q & AVS_WRITE & ~rst_all;
    wire          rd      = ack_q & AVS_READ;
    wire          wr_idx  = wr & hit_idx;
    wire          wr_ctl  = wr & hit_ctl;
    wire          wr_st   = wr & hit_st;
    wire          wr_sk   = wr & hit_sk;
    wire          wr_cmd  = wr & hit_cmd;
    wire          wr_ext  = wr & hit_ext;
    wire          rd_st   = rd & hit_st;

    // Byte lane n covers bits 8n+7..8n
    wire [DW-1:0] bmask = {{8{be[3]}}, {8{be[2]}},
                           {8{be[1]}}, {8{be[0]}}};
    wire [DW-1:0] wd    = AVS_WRITEDATA;
    wire [DW-1:0] wone  = wd & bmask;

    // ********************************
    // Next values
    // ********************************
    wire [LKF_W-1:0] lkf_m = bmask[LKF_LSB +: LKF_W];
    wire [LKF_W-1:0] lkf_d = (lkf_q & ~lkf_m)
                           | (wd[LKF_LSB +: LKF_W] & lkf_m);
    wire             wo_we = wr_ctl & bmask[WO_LSB] & ~wo_done_q;
    wire [SC_W-1:0]  sc_wm = wr_ctl ? bmask[SC_LSB +: SC_W]
                                      & {~lock_q, 1'h1}
                                    : '0;
    wire [SC_W-1:0]  sc_d  = (sc_q & ~SC_DONE & ~sc_wm)
                           | (wd[SC_LSB +: SC_W] & sc_wm);
    wire [DW-1:0]    sk_d  = (stky_q & ~bmask) | wone;
    wire [DW-1:0]    ext_d = (ext_q & ~bmask) | wone;
    wire [DW-1:0]    idx_d = (index_q & ~bmask) | wone;

    // ********************************
    // Status bit groups
    // ********************************
    wire [EV_W-1:0] ev_clr  = wr_st ? wone[0 +: EV_W] : '0;
    wire [EV_W-1:0] sev_clr = wr_st ? wone[SEV_LSB +: EV_W] : '0;

    cra_w1c_bits #(
        .W      (EV_W),
        .STICKY (1'h0)
    ) u_ev (
        .clk    (CLOCK),
        .rif    (rif),
        .set    (HW_EVENT[0 +: EV_W]),
        .clr    (ev_clr),
        .q      (ev_q)
    );

    cra_w1c_bits #(
        .W      (EV_W),
        .STICKY (1'h1)
    ) u_sev (
        .clk    (CLOCK),
        .rif    (rif),
        .set    (HW_EVENT[EV_W +: EV_W]),
        .clr    (sev_clr),
        .q      (sev_q)
    );

    // ********************************
    // Read mux
    // ********************************
    wire [DW-1:0] id_rd  = DW'(rif.strap)
                         | (DW'(PART_CODE) << ID_CODE_LSB);
    wire [DW-1:0] ctl_rd = (DW'(lock_q) << LOCK_BIT)
                         | (DW'(lkf_q) << LKF_LSB)
                         | (DW'(wo_q) << WO_LSB)
                         | (DW'(sc_q) << SC_LSB);
    wire [DW-1:0] st_rd  = DW'(ev_q)
                         | (DW'(sev_q) << SEV_LSB)
                         | (DW'(rs_q) << RS_BIT)
                         | (DW'(rwc_q) << RWC_LSB);
    wire [DW-1:0] rd_val = hit_idx ? index_q
                         : hit_id  ? id_rd
                         : hit_ctl ? ctl_rd
                         : hit_st  ? st_rd
                         : hit_sk  ? stky_q
                         : hit_ext ? ext_q
                         : '0;

    // ********************************
    // Bus handshake
    // ********************************
    always_ff @(posedge CLOCK) begin
        if (rst_all) begin
            ack_q   <= 1'h0;
            wait_q  <= 1'h1;
            rdata_q <= '0;
        end else begin
            ack_q  <= req;
            wait_q <= ~req;
            if (req && AVS_READ) begin
                rdata_q <= rd_val;
            end
        end
    end

    // ********************************
    // Control register
    // ********************************
    always_ff @(posedge CLOCK) begin
        if (rst_all) begin
            lock_q <= 1'h0;
            lkf_q  <= rif.strap;
            sc_q   <= '0;
        end else begin
            if (wr_ctl && wone[LOCK_BIT]) begin
                lock_q <= 1'h1;
            end
            if (wr_ctl && !lock_q) begin
                lkf_q <= lkf_d;
            end
            sc_q <= sc_d;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (rst_all) begin
            wo_q      <= '0;
            wo_done_q <= 1'h0;
        end else if (wo_we) begin
            wo_q      <= wd[WO_LSB +: WO_W];
            wo_done_q <= 1'h1;
        end
    end

    // ********************************
    // Status extras
    // ********************************
    always_ff @(posedge CLOCK) begin
        if (rst_all) begin
            rs_q  <= 1'h0;
            rwc_q <= RWC_RST;
        end else begin
            if (wr_st && wone[RS_BIT]) begin
                rs_q <= 1'h0;
            end else if (rd_st && be[RS_BIT / 8]) begin
                rs_q <= 1'h1;
            end
            if (wr_st) begin
                rwc_q <= rwc_q & ~wone[RWC_LSB +: RWC_W];
            end
        end
    end

    // ********************************
    // Sticky, extended, index and command
    // ********************************
    always_ff @(posedge CLOCK) begin
        if (rif.cold) begin
            stky_q <= '0;
        end else if (wr_sk) begin
            stky_q <= sk_d;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (rst_all) begin
            ext_q   <= '0;
            index_q <= '0;
        end else begin
            if (wr_ext) begin
                ext_q <= ext_d;
            end
            if (wr_idx) begin
                index_q <= idx_d;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (rst_all) begin
            pulse_q <= 1'h0;
            cmd_q   <= '0;
        end else begin
            pulse_q <= wr_cmd;
            if (wr_cmd) begin
                cmd_q <= wone;
            end
        end
    end

    // ********************************
    // Outputs
    // ********************************
    assign AVS_READDATA     = rdata_q;
    assign AVS_WAITREQUEST  = wait_q;
    assign LOCKED_FIELD     = lkf_q;
    assign WRITE_ONCE_FIELD = wo_q;
    assign SC_CMD           = sc_q;
    assign STICKY_CFG       = stky_q;
    assign EXT_CFG          = ext_q;
    assign CMD_PULSE        = pulse_q;
    assign CMD_DATA         = cmd_q;

    // ********************************
    // Checks
    // ********************************
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (rst_all);

    ro_write_a: assert property (
        (wr && (hit_id || rsvd)) |=>
        $stable({lock_q, lkf_q, wo_q, index_q, rs_q, rwc_q, stky_q, ext_q}))
        else $error("write to read-only location changed state");
    rs_set_a: assert property (
        (rd_st && be[RS_BIT / 8]) |=> rs_q)
        else $error("read did not set the read-set bit");
    lock_hold_a: assert property (
        (lock_q && wr_ctl) |=> $stable(lkf_q))
        else $error("locked field took a write");
    lock_keep_a: assert property (
        lock_q |=> lock_q)
        else $error("lock bit cleared without reset");
    wo_hold_a: assert property (
        wo_done_q |=> $stable(wo_q) && wo_done_q)
        else $error("write-once field changed after first write");
    wonly_zero_a: assert property (
        (rd && hit_cmd) |-> AVS_READDATA == '0)
        else $error("write-only register echoed data");
    rsvd_zero_a: assert property (
        (rd && rsvd) |-> AVS_READDATA == '0)
        else $error("reserved location read nonzero");
    ack_one_a: assert property (
        req |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
        else $error("access not completed in one cycle");
    sticky_warm_a: assert property (
        @(posedge CLOCK) disable iff (rif.cold)
        rif.warm |=> $stable(stky_q))
        else $error("sticky register lost on warm reset");
    dword_only_a: assert property (
        (wr && !low_rgn && be != BE_ALL) |=> $stable(ext_q))
        else $error("partial write reached extended region");
endmodule : cra_bank

// ===== test/cra_host.sv
// Host model: Avalon-MM master, one access at a time
// Assumes a slave that answers by dropping waitrequest
`timescale 1ns/1ns
module cra_host (
    input  wire logic                   clk,
    output logic [cra_pkg::AW-1:0]      address,
    output logic                        read,
    output logic                        write,
    output logic [cra_pkg::DW-1:0]      writedata,
    output logic [cra_pkg::BW-1:0]      byteenable,
    input  wire logic [cra_pkg::DW-1:0] readdata,
    input  wire logic                   waitrequest
);
    import cra_pkg::*;
    initial begin
        address = '0;
        read = 1'b0;
        write = 1'b0;
        writedata = '0;
        byteenable = '0;
    end
    // Reserved places also written and read by callers
    task automatic xfer(input logic wr, input logic [AW-1:0] a,
                        input logic [DW-1:0] d, input logic [BW-1:0] be,
                        output logic [DW-1:0] rd);
        @(posedge clk);
        address <= a;
        read <= !wr;
        write <= wr;
        writedata <= d;
        byteenable <= be;  // Width picked by caller
        @(posedge clk);
        while (waitrequest !== 1'h0) begin
            @(posedge clk);
        end
        rd = readdata;
        read <= 1'h0;
        write <= 1'h0;
        writedata <= ~d;
        byteenable <= ~be;
        @(negedge clk);
    endtask : xfer
endmodule : cra_host

// ===== test/tb.sv
// Testbench for the attribute bank
// Assumes the bank answers reads and writes through waitrequest
`timescale 1ns/1ns
module tb;
    import cra_pkg::*;
    localparam int          CPU_N = 20;
    localparam logic [15:0] CODE  = 16'h2B71;  // Arbitrary value
    logic          clk, srst, rst_in_n, cpu_rst_n, rd_, wr_, wait_;
    logic          cmd_pulse;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata, rdata, sticky, ext, cmd_data;
    logic [BW-1:0] be;
    logic [3:0]    strap, lkf;
    logic [15:0]   hw_event;
    logic [1:0]    sc_done, sc_cmd;
    logic [7:0]    wo;
    int            fail_count, cmp_count;
    int            pulse_n = 0;
    cra_bank #(.CPU_RST_CYCLES(CPU_N), .PART_CODE(CODE)) i_cra_bank (
        .CLOCK(clk), .SRST(srst), .AVS_ADDRESS(addr), .AVS_READ(rd_),
        .AVS_WRITE(wr_), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be),
        .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_),
        .SYSTEM_RESET_IN_N(rst_in_n), .STRAP_IN(strap),
        .HW_EVENT(hw_event), .SC_DONE(sc_done),
        .PROCESSOR_RESET_OUT_N(cpu_rst_n), .LOCKED_FIELD(lkf),
        .WRITE_ONCE_FIELD(wo), .SC_CMD(sc_cmd), .STICKY_CFG(sticky),
        .EXT_CFG(ext), .CMD_PULSE(cmd_pulse), .CMD_DATA(cmd_data));
    cra_host i_cra_host (.clk(clk), .address(addr), .read(rd_),
        .write(wr_), .writedata(wdata), .byteenable(be),
        .readdata(rdata), .waitrequest(wait_));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) if (cmd_pulse === 1'b1) pulse_n <= pulse_n + 1;
    task automatic check(input string nm, input logic [DW-1:0] seen,
                         input logic [DW-1:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d,
                      input logic [BW-1:0] b);
        logic [DW-1:0] r;
        i_cra_host.xfer(1'b1, a, d, b, r);
    endtask : wr
    task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] exp,
                      input string nm);
        logic [DW-1:0] r;
        i_cra_host.xfer(1'b0, a, '0, BE_ALL, r);
        check(nm, r, exp);
    endtask : rd
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic cold(input logic [3:0] s);
        @(posedge clk);
        strap <= s;
        srst <= 1'b1;
        cyc(20);
        srst <= 1'b0;
        @(negedge clk);
    endtask : cold
    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done
    initial begin
        #100000;
        fail_count++;
        test_done();
    end
    initial begin
        srst = 1'b1;
        rst_in_n = 1'b1;
        strap = 4'hA;
        hw_event = '0;
        sc_done = '0;
        fail_count = 0;
        cmp_count = 0;
        cold(4'hA);
        check("cpu_rst", 32'(cpu_rst_n), 32'h0);
        cyc(CPU_N - 3);
        @(negedge clk);
        check("cpu_rst", 32'(cpu_rst_n), 32'h0);
        cyc(6);
        @(negedge clk);
        check("cpu_rst", 32'(cpu_rst_n), 32'h1);
        rd(IX_ID, {CODE, 16'h000A}, "id");
        wr(IX_ID, '1, BE_ALL);
        rd(IX_ID, {CODE, 16'h000A}, "id");
        check("lkf", 32'(lkf), 32'hA);
        wr(IX_CTRL, 32'h0000_0050, 4'h1);
        check("lkf", 32'(lkf), 32'h5);
        wr(IX_CTRL, 32'h0000_3C00, 4'h2);
        wr(IX_CTRL, 32'h0000_1100, 4'h2);
        check("wo", 32'(wo), 32'h3C);
        wr(IX_CTRL, 32'h0000_0051, 4'h1);
        wr(IX_CTRL, 32'h0000_0030, 4'h1);
        check("lkf", 32'(lkf), 32'h5);
        rd(IX_CTRL, 32'h0000_3C51, "ctrl");
        wr(IX_CTRL, 32'h0003_0000, 4'h4);
        check("sc", 32'(sc_cmd), 32'h1);
        @(posedge clk);
        sc_done <= 2'h3;
        @(posedge clk);
        sc_done <= 2'h0;
        @(negedge clk);
        check("sc", 32'(sc_cmd), 32'h0);
        @(posedge clk);
        hw_event <= 16'h0208;
        @(posedge clk);
        hw_event <= 16'h0000;
        rd(IX_STAT, 32'h000E_0208, "stat");
        rd(IX_STAT, 32'h000F_0208, "stat");
        wr(IX_STAT, 32'h0000_0000, BE_ALL);
        rd(IX_STAT, 32'h000F_0208, "stat");
        wr(IX_STAT, 32'h0003_0008, BE_ALL);
        rd(IX_STAT, 32'h000C_0200, "stat");
        wr(IX_STKY, 32'hA5A5_5A5A, BE_ALL);
        wr(IX_STKY, 32'h0000_00EE, 4'h1);
        rd(IX_STKY, 32'hA5A5_5AEE, "stky");
        wr(IX_STKY, 32'h0000_0000, 4'h6);
        rd(IX_STKY, 32'hA5A5_5AEE, "stky");
        wr(IX_EXT, 32'h1111_2222, BE_ALL);
        wr(IX_EXT, 32'h0000_0000, BE_LO16);
        check("ext", ext, 32'h1111_2222);
        wr(IX_INDEX, '1, BE_ALL);
        wr(IX_INDEX, '0, 4'h1);
        rd(IX_INDEX, 32'hFFFF_FFFF, "index");
        wr(IX_CMD, 32'h1234_5678, BE_ALL);
        cyc(3);
        check("cmd", cmd_data, 32'h1234_5678);
        check("pulses", 32'(pulse_n), 32'h1);
        rd(IX_CMD, 32'h0, "cmd");
        wr(10'h006, '1, BE_ALL);
        rd(10'h006, 32'h0, "rsvd");
        rd(10'h3FF, 32'h0, "rsvd");
        check("stky", sticky, 32'hA5A5_5AEE);
        @(posedge clk);
        rst_in_n <= 1'b0;
        cyc(6);
        rst_in_n <= 1'b1;
        cyc(6);
        @(negedge clk);
        rd(IX_STKY, 32'hA5A5_5AEE, "stky");
        rd(IX_STAT, 32'h000E_0200, "stat");
        check("lkf", 32'(lkf), 32'hA);
        check("wo", 32'(wo), 32'h0);
        cold(4'h3);
        rd(IX_STKY, 32'h0, "stky");
        rd(IX_STAT, 32'h000E_0000, "stat");
        rd(IX_ID, {CODE, 16'h0003}, "id");
        check("lkf", 32'(lkf), 32'h3);
        test_done();
    end
endmodule : tb
